// File: fmc_pkg.sv
// Constants, encodings and types of the flash command sequencer.
// Assumes a 200 MHz bus clock; all users import this package.
package fmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_STATUS = 8'h00; // Flags, launch
  localparam logic [7:0] OFF_INDEX = 8'h04;  // Slot index
  localparam logic [7:0] OFF_PARAM = 8'h08;  // Slot at index
  localparam logic [7:0] OFF_CONFIG = 8'h0C; // Mode bits
  localparam logic [7:0] OFF_PROT = 8'h10;   // Protection
  localparam logic [7:0] OFF_MARGIN = 8'h14; // Margin state
  localparam int ADR_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ST_CMD_COMPLETE_FLAG_BIT = 7;
  localparam int ST_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int ST_PVIOL_BIT = 4;
  localparam int ST_VS1_BIT = 1;
  localparam int ST_VS0_BIT = 0;
  localparam int CFG_SPECIAL_BIT = 0; // Special operating mode
  localparam int CFG_EEPGM_BIT = 1;   // EEPROM program available
  localparam int PROT_EN_BIT = 16;
  localparam int MARGIN_EE_LSB = 4;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 8;
  localparam int IDX_W = 3;
  localparam int MARGIN_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Commands, slots and codes
  localparam logic [7:0] CMD_SET_FIELD_MARGIN = 8'h0E;
  localparam logic [7:0] CMD_PROGRAM_EEPROM = 8'h11;
  localparam logic [7:0] CMD_ERASE_EE_SECTOR = 8'h12;
  localparam int NUM_SLOTS = 6;
  localparam logic [2:0] SLOT_CMD = 3'h0;
  localparam logic [2:0] SLOT_ADDR = 3'h1;
  localparam logic [2:0] SLOT_WORD0 = 3'h2;
  localparam logic [2:0] SLOT_WORD3 = 3'h5;
  localparam logic [1:0] BLK_PFLASH = 2'h0;
  localparam logic [1:0] BLK_EEPROM = 2'h1;
  localparam logic [15:0] MARGIN_NORMAL = 16'h0000;
  localparam logic [15:0] MARGIN_USER_1 = 16'h0001;
  localparam logic [15:0] MARGIN_USER_0 = 16'h0002;
  localparam logic [15:0] MARGIN_FIELD_1 = 16'h0003;
  localparam logic [15:0] MARGIN_FIELD_0 = 16'h0004;
  localparam logic [1:0] BIAS_NONE = 2'h0;       // Normal read
  localparam logic [1:0] BIAS_ERASED = 2'h1;     // Toward erased
  localparam logic [1:0] BIAS_PROGRAMMED = 2'h2; // Toward programmed
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int OP_TIME_NS = 500; // Per word program, per sector erase
  localparam int OP_CYCLES = (OP_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
  localparam int TMR_W = 12;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_PROG, ST_VERIFY, ST_ERASE, ST_DONE
  } fmc_state_type;

  // Read bias of a margin level
  function automatic logic [1:0] fmc_bias(input logic [2:0] lvl);
    logic [1:0] b;
    b = BIAS_NONE;
    if (lvl == MARGIN_USER_1[2:0] || lvl == MARGIN_FIELD_1[2:0]) begin
      b = BIAS_ERASED;
    end else if (lvl == MARGIN_USER_0[2:0] || lvl == MARGIN_FIELD_0[2:0]) begin
      b = BIAS_PROGRAMMED;
    end
    return b;
  endfunction

endpackage

// File: fmc_ee_array.sv
// EEPROM word storage held in flip-flops.
// Assumes at most one of program and erase per cycle from the sequencer.
`timescale 1ns/1ps
module fmc_ee_array #(
  parameter int WORDS = 64,
  parameter int SECTOR_WORDS = 8,
  parameter int IW = $clog2(WORDS)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic prog_en_i,
  input wire logic [IW-1:0] prog_idx_i,
  input wire logic [15:0] prog_data_i,
  input wire logic erase_en_i,
  input wire logic [IW-1:0] erase_idx_i,
  input wire logic [IW-1:0] rd_idx_i,
  output logic [15:0] rd_data_o
);
  import fmc_pkg::*;

  localparam int SW = $clog2(SECTOR_WORDS);

  logic [15:0] mem_reg [WORDS]; // Stored words
  logic [15:0] mem_next [WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // One cell per word
  genvar i;
  generate
    for (i = 0; i < WORDS; i++) begin : g_word
      // Program only clears bits, so a reprogram cannot set them again
      always_comb begin
        mem_next[i] = mem_reg[i];
        if (erase_en_i && (IW'(i) >> SW) == (erase_idx_i >> SW)) begin
          mem_next[i] = ERASED_WORD;
        end else if (prog_en_i && prog_idx_i == IW'(i)) begin
          mem_next[i] = mem_reg[i] & prog_data_i;
        end
      end
      // Reset leaves the array erased
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mem_reg[i] <= ERASED_WORD;
        end else begin
          mem_reg[i] <= mem_next[i];
        end
      end
    end
  endgenerate

  // Read port for verify
  assign rd_data_o = mem_reg[rd_idx_i];

endmodule

// File: fmc_ctrl.sv
// Command sequencer for field margin and EEPROM program commands.
// Assumes a classic Wishbone master on the same clock and a sync reset.
`timescale 1ns/1ps

// What this block does
// [R01] Margin command 0x0E accepted in special modes only
// [R02] Slot 0 code and block select, slot 1 level
// [R03] Margin launch applies level, then sets complete
// [R04] EEPROM target changes EEPROM read margin only
// [R05] Flash target changes both flash and EEPROM margin
// [R06] Levels 0 to 4: normal, user, field margins
// [R07] Margin-1 biases erased, margin-0 biases programmed
// [R08] Program 0x11 writes one to four words, verifies
// [R09] Slots hold address high, low, then words
// [R10] Index at launch sets count; unprotected; complete
// [R11] Index below 2 or above 5 is access error
// [R12] Unavailable mode or bad address is access error
// [R13] Odd address is access error
// [R14] Words past EEPROM end is access error
// [R15] Protected area sets violation, no programming
// [R16] Verify errors set status bits one and zero
// [R17] Host programs only erased words
// [R18] Sector erase clears every word in sector
// [R19] Unknown command code is access error
// [R20] Host clears errors before next command
// [R21] Host loads slots before launch, not during
module fmc_ctrl #(
  parameter logic [17:0] EE_BASE = 18'h00400, // Global byte address
  parameter int EE_WORDS = 64,
  parameter int SECTOR_WORDS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fmc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic cmd_complete_o,
  output logic [fmc_pkg::MARGIN_W-1:0] pf_margin_o,
  output logic [fmc_pkg::MARGIN_W-1:0] ee_margin_o,
  output logic [1:0] pf_bias_o,
  output logic [1:0] ee_bias_o
);
  import fmc_pkg::*;

  localparam int IW = $clog2(EE_WORDS);
  localparam logic [18:0] EE_BASE_X = {1'b0, EE_BASE};
  localparam logic [18:0] EE_END = EE_BASE_X + 19'(2 * EE_WORDS) - 19'd1;
  localparam logic [18:0] SECT_MASK = 19'(2 * SECTOR_WORDS - 1);
  localparam logic [TMR_W-1:0] OP_LOAD = TMR_W'(OP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic ack_reg, ack_next;             // Bus answer
  logic [31:0] rdata_reg, rdata_next;  // Read data
  logic [2:0] index_reg, index_next;   // Slot index
  logic [15:0] slot_reg [NUM_SLOTS];   // Parameter slots
  logic [15:0] slot_next [NUM_SLOTS];
  logic cmd_complete_flag_reg, cmd_complete_flag_next;           // Command complete
  logic access_error_flag_reg, access_error_flag_next;
  logic pviol_reg, pviol_next;
  logic vs1_reg, vs1_next;
  logic vs0_reg, vs0_next;
  logic special_reg, special_next;     // Special mode
  logic eepgm_reg, eepgm_next;         // Program available
  logic prot_en_reg, prot_en_next;
  logic [15:0] prot_base_reg, prot_base_next; // Protected from offset
  logic [2:0] pfm_reg, pfm_next;       // Flash margin level
  logic [2:0] eem_reg, eem_next;       // EEPROM margin level
  logic [1:0] pfb_reg, pfb_next;       // Flash read bias, registered
  logic [1:0] eeb_reg, eeb_next;       // EEPROM read bias, registered
  fmc_state_type state_reg, state_next;
  logic [2:0] lidx_reg, lidx_next;     // Index captured at launch
  logic [1:0] wcnt_reg, wcnt_next;     // Word counter
  logic [IW-1:0] wbase_reg, wbase_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the request and the slots
  logic wb_req, wr, rd, launch;
  logic [7:0] cmd_w;
  logic [17:0] gaddr_w;
  logic [2:0] nwords_w;
  logic [18:0] off_w, last_w, last_off_w;
  logic addr_ok, breach, prot_hit, idx_bad, lvl_ok;
  logic [IW-1:0] widx_w;
  logic [15:0] rd_word;
  logic mismatch, prog_en, erase_en;
  logic [2:0] vslot_w;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = wb_req & wb_we_i;
  assign rd = wb_req & ~wb_we_i;
  // Launch is ignored while an old access error or protection violation is still pending
  assign launch = wr && wb_adr_i == OFF_STATUS && wb_sel_i[0]
                  && wb_dat_i[ST_CMD_COMPLETE_FLAG_BIT] && cmd_complete_flag_reg
                  && !access_error_flag_reg && !pviol_reg;
  assign cmd_w = slot_reg[SLOT_CMD][CMD_HI:CMD_LO]; // see [R02] [R09]
  assign gaddr_w = {slot_reg[SLOT_CMD][1:0], slot_reg[SLOT_ADDR]};
  assign nwords_w = 3'(lidx_reg - SLOT_WORD0 + 3'd1); // see [R10]
  assign off_w = {1'b0, gaddr_w} - EE_BASE_X;
  assign last_w = {1'b0, gaddr_w} + {15'd0, nwords_w, 1'b0} - 19'd1;
  // Erase spans a sector, program spans its words
  assign last_off_w = (cmd_w == CMD_ERASE_EE_SECTOR) ? (off_w | SECT_MASK)
                      : (last_w - EE_BASE_X);
  assign addr_ok = {1'b0, gaddr_w} >= EE_BASE_X
                   && {1'b0, gaddr_w} <= EE_END; // see [R12]
  assign breach = last_w > EE_END; // see [R14]
  // Upper part of the EEPROM, from the base offset on, is locked
  assign prot_hit = prot_en_reg && last_off_w >= {3'd0, prot_base_reg};
  assign idx_bad = lidx_reg < SLOT_WORD0 || lidx_reg > SLOT_WORD3;
  assign lvl_ok = slot_reg[SLOT_ADDR] <= MARGIN_FIELD_0; // see [R06]
  assign widx_w = off_w[IW:1];
  assign vslot_w = 3'(SLOT_WORD0 + {1'b0, wcnt_reg});
  assign mismatch = rd_word != slot_reg[vslot_w]; // see [R16]
  assign prog_en = state_reg == ST_PROG && tmr_reg == '0;
  assign erase_en = state_reg == ST_ERASE && tmr_reg == '0; // see [R18]

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  fmc_ee_array #(
    .WORDS(EE_WORDS),
    .SECTOR_WORDS(SECTOR_WORDS)
  ) u_array (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .prog_en_i(prog_en), // see [R08]
    .prog_idx_i(wbase_reg + IW'(wcnt_reg)),
    .prog_data_i(slot_reg[vslot_w]),
    .erase_en_i(erase_en),
    .erase_idx_i(wbase_reg),
    .rd_idx_i(wbase_reg + IW'(wcnt_reg)),
    .rd_data_o(rd_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait state, unmapped reads give zero
  always_comb begin
    ack_next = wb_req;
    rdata_next = '0;
    if (rd) begin
      case (wb_adr_i)
        OFF_STATUS: begin
          rdata_next[ST_CMD_COMPLETE_FLAG_BIT] = cmd_complete_flag_reg;
          rdata_next[ST_ACCESS_ERROR_FLAG_BIT] = access_error_flag_reg;
          rdata_next[ST_PVIOL_BIT] = pviol_reg;
          rdata_next[ST_VS1_BIT] = vs1_reg;
          rdata_next[ST_VS0_BIT] = vs0_reg;
        end
        OFF_INDEX: rdata_next[IDX_W-1:0] = index_reg;
        OFF_PARAM: begin
          if (index_reg <= SLOT_WORD3) begin
            rdata_next[15:0] = slot_reg[index_reg];
          end
        end
        OFF_CONFIG: begin
          rdata_next[CFG_SPECIAL_BIT] = special_reg;
          rdata_next[CFG_EEPGM_BIT] = eepgm_reg;
        end
        OFF_PROT: rdata_next[PROT_EN_BIT:0] = {prot_en_reg, prot_base_reg};
        OFF_MARGIN: begin
          rdata_next[MARGIN_W-1:0] = pfm_reg;
          rdata_next[MARGIN_EE_LSB +: MARGIN_W] = eem_reg;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and the command sequencer
  always_comb begin
    logic set_acc, set_pv, set_vs, clr_acc, clr_pv, busy;
    set_acc = 1'b0;
    set_pv = 1'b0;
    set_vs = 1'b0;
    clr_acc = 1'b0;
    clr_pv = 1'b0;
    busy = !cmd_complete_flag_reg;
    index_next = index_reg;
    slot_next = slot_reg;
    cmd_complete_flag_next = cmd_complete_flag_reg;
    vs1_next = vs1_reg;
    vs0_next = vs0_reg;
    special_next = special_reg;
    eepgm_next = eepgm_reg;
    prot_en_next = prot_en_reg;
    prot_base_next = prot_base_reg;
    pfm_next = pfm_reg;
    eem_next = eem_reg;
    state_next = state_reg;
    lidx_next = lidx_reg;
    wcnt_next = wcnt_reg;
    wbase_next = wbase_reg;
    tmr_next = tmr_reg;
    // Software side; slots and index freeze while a command runs
    if (wr) begin
      case (wb_adr_i)
        OFF_STATUS: begin
          clr_acc = wb_sel_i[0] & wb_dat_i[ST_ACCESS_ERROR_FLAG_BIT];
          clr_pv = wb_sel_i[0] & wb_dat_i[ST_PVIOL_BIT];
        end
        OFF_INDEX: if (!busy && wb_sel_i[0]) index_next = wb_dat_i[2:0];
        OFF_PARAM: begin
          if (!busy && index_reg <= SLOT_WORD3) begin
            if (wb_sel_i[0]) slot_next[index_reg][7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) slot_next[index_reg][15:8] = wb_dat_i[15:8];
          end
        end
        OFF_CONFIG: begin
          if (wb_sel_i[0]) begin
            special_next = wb_dat_i[CFG_SPECIAL_BIT];
            eepgm_next = wb_dat_i[CFG_EEPGM_BIT];
          end
        end
        OFF_PROT: begin
          if (wb_sel_i[0]) prot_base_next[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) prot_base_next[15:8] = wb_dat_i[15:8];
          if (wb_sel_i[2]) prot_en_next = wb_dat_i[PROT_EN_BIT];
        end
        default: ;
      endcase
    end
    case (state_reg)
      ST_IDLE: begin
        if (launch) begin
          cmd_complete_flag_next = 1'b0;
          vs1_next = 1'b0;
          vs0_next = 1'b0;
          lidx_next = index_reg; // see [R10]
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        state_next = ST_DONE;
        wbase_next = widx_w;
        wcnt_next = '0;
        tmr_next = OP_LOAD;
        case (cmd_w)
          CMD_SET_FIELD_MARGIN: begin
            if (!special_reg || !lvl_ok) begin
              set_acc = 1'b1; // see [R01]
            end else if (slot_reg[SLOT_CMD][1:0] == BLK_EEPROM) begin
              eem_next = slot_reg[SLOT_ADDR][2:0]; // see [R03] [R04]
            end else if (slot_reg[SLOT_CMD][1:0] == BLK_PFLASH) begin
              pfm_next = slot_reg[SLOT_ADDR][2:0]; // see [R05]
              eem_next = slot_reg[SLOT_ADDR][2:0];
            end else begin
              set_acc = 1'b1;
            end
          end
          CMD_PROGRAM_EEPROM, CMD_ERASE_EE_SECTOR: begin
            // see [R11] [R12] [R13] [R14]
            if ((cmd_w == CMD_PROGRAM_EEPROM && idx_bad) || !eepgm_reg
                || !addr_ok || gaddr_w[0] || breach) begin
              set_acc = 1'b1;
            end else if (prot_hit) begin
              set_pv = 1'b1; // see [R15]
            end else begin
              state_next = (cmd_w == CMD_PROGRAM_EEPROM) ? ST_PROG
                           : ST_ERASE;
            end
          end
          default: set_acc = 1'b1; // see [R19]
        endcase
      end
      ST_PROG: begin
        if (tmr_reg != '0) begin
          tmr_next = tmr_reg - 1'b1;
        end else if (3'(wcnt_reg) == nwords_w - 3'd1) begin
          wcnt_next = '0;
          state_next = ST_VERIFY; // see [R08]
        end else begin
          wcnt_next = wcnt_reg + 1'b1;
          tmr_next = OP_LOAD;
        end
      end
      ST_VERIFY: begin
        set_vs = mismatch; // No correction, so any miss is fatal
        wcnt_next = wcnt_reg + 1'b1;
        if (3'(wcnt_reg) == nwords_w - 3'd1) state_next = ST_DONE;
      end
      ST_ERASE: begin
        tmr_next = tmr_reg - 1'b1;
        if (tmr_reg == '0) state_next = ST_DONE;
      end
      ST_DONE: begin
        cmd_complete_flag_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    // A hardware set wins over a software clear in the same cycle
    access_error_flag_next = (access_error_flag_reg & ~clr_acc) | set_acc;
    pviol_next = (pviol_reg & ~clr_pv) | set_pv;
    if (set_vs) begin
      vs1_next = 1'b1; // see [R16]
      vs0_next = 1'b1;
    end
    // Bias follows the next level, so it never lags the margin outputs
    pfb_next = fmc_bias(pfm_next); // see [R07]
    eeb_next = fmc_bias(eem_next);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      index_reg <= '0;
      for (int k = 0; k < NUM_SLOTS; k++) slot_reg[k] <= '0;
      cmd_complete_flag_reg <= 1'b1;
      access_error_flag_reg <= 1'b0;
      pviol_reg <= 1'b0;
      vs1_reg <= 1'b0;
      vs0_reg <= 1'b0;
      special_reg <= 1'b0;
      eepgm_reg <= 1'b0;
      prot_en_reg <= 1'b0;
      prot_base_reg <= '0;
      pfm_reg <= MARGIN_NORMAL[2:0];
      eem_reg <= MARGIN_NORMAL[2:0];
      pfb_reg <= BIAS_NONE;
      eeb_reg <= BIAS_NONE;
      state_reg <= ST_IDLE;
      lidx_reg <= '0;
      wcnt_reg <= '0;
      wbase_reg <= '0;
      tmr_reg <= '0;
    end else begin
      index_reg <= index_next;
      slot_reg <= slot_next;
      cmd_complete_flag_reg <= cmd_complete_flag_next;
      access_error_flag_reg <= access_error_flag_next;
      pviol_reg <= pviol_next;
      vs1_reg <= vs1_next;
      vs0_reg <= vs0_next;
      special_reg <= special_next;
      eepgm_reg <= eepgm_next;
      prot_en_reg <= prot_en_next;
      prot_base_reg <= prot_base_next;
      pfm_reg <= pfm_next;
      eem_reg <= eem_next;
      pfb_reg <= pfb_next;
      eeb_reg <= eeb_next;
      state_reg <= state_next;
      lidx_reg <= lidx_next;
      wcnt_reg <= wcnt_next;
      wbase_reg <= wbase_next;
      tmr_reg <= tmr_next;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign cmd_complete_o = cmd_complete_flag_reg;
  assign pf_margin_o = pfm_reg;
  assign ee_margin_o = eem_reg;
  assign pf_bias_o = pfb_reg; // see [R07]
  assign ee_bias_o = eeb_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Error screen seen by the protection check
  logic set_acc_w;
  assign set_acc_w = idx_bad || !eepgm_reg || !addr_ok || gaddr_w[0]
                     || breach;

  sequence s_margin_chk;
    state_reg == ST_CHECK && cmd_w == CMD_SET_FIELD_MARGIN && special_reg
      && lvl_ok;
  endsequence
  sequence s_done_seen;
    state_reg == ST_DONE ##1 cmd_complete_flag_reg;
  endsequence

  margin_mode_a: assert property (state_reg == ST_CHECK // see [R01]
    && cmd_w == CMD_SET_FIELD_MARGIN && !special_reg
    |=> access_error_flag_reg && $stable(pfm_reg) && $stable(eem_reg))
    else $error("margin taken outside special mode");
  margin_done_a: assert property (s_margin_chk |=> s_done_seen) // see [R03]
    else $error("margin command did not complete");
  ee_only_a: assert property (s_margin_chk // see [R04]
    and slot_reg[SLOT_CMD][1:0] == BLK_EEPROM
    |=> $stable(pfm_reg) && eem_reg == $past(slot_reg[SLOT_ADDR][2:0]))
    else $error("eeprom margin leaked to flash");
  pf_both_a: assert property (s_margin_chk // see [R05]
    and slot_reg[SLOT_CMD][1:0] == BLK_PFLASH |=> pfm_reg == eem_reg)
    else $error("flash margin not applied to both");
  bias_map_a: assert property (ee_margin_o == MARGIN_FIELD_0[2:0] // see [R07]
    |-> ee_bias_o == BIAS_PROGRAMMED)
    else $error("margin-0 bias wrong");
  idx_range_a: assert property (state_reg == ST_CHECK // see [R11]
    && cmd_w == CMD_PROGRAM_EEPROM && idx_bad
    |=> access_error_flag_reg && state_reg == ST_DONE ##1 cmd_complete_flag_reg)
    else $error("bad index not refused");
  misalign_a: assert property (state_reg == ST_CHECK // see [R13]
    && cmd_w == CMD_PROGRAM_EEPROM && gaddr_w[0] |=> access_error_flag_reg)
    else $error("odd address not refused");
  prot_a: assert property (state_reg == ST_CHECK && !set_acc_w // see [R15]
    && cmd_w == CMD_PROGRAM_EEPROM && prot_hit
    |=> pviol_reg && state_reg == ST_DONE)
    else $error("protected area programmed");
  bad_cmd_a: assert property (state_reg == ST_CHECK // see [R19]
    && cmd_w != CMD_PROGRAM_EEPROM && cmd_w != CMD_ERASE_EE_SECTOR
    && cmd_w != CMD_SET_FIELD_MARGIN |=> access_error_flag_reg)
    else $error("unknown command not refused");
  verify_set_a: assert property (state_reg == ST_VERIFY // see [R16]
    && mismatch |=> vs1_reg && vs0_reg)
    else $error("verify miss not flagged");
  ack_pulse_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");

endmodule

// File: fmc_ctrl_bench.sv
// Bench for the margin and EEPROM program command sequencer.
// Assumes fmc_pkg is compiled first; drives Wishbone from the bench.
`timescale 1ns/1ps
module fmc_ctrl_bench;
  import fmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [17:0] BASE = 18'h00400; // EEPROM global base
  logic clk = 1'b0;
  logic rst = 1'b1; // Sync reset, high
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic ack, done;
  logic [2:0] pf_m, ee_m;
  logic [1:0] pf_b, ee_b;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int waited; // Cycles until complete returned
  int lv;

  fmc_ctrl uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .cmd_complete_o(done),
    .pf_margin_o(pf_m), .ee_margin_o(ee_m), .pf_bias_o(pf_b),
    .ee_bias_o(ee_b));

  // 200 MHz clock
  initial forever #2.5 clk = ~clk;

  // Hang guard, well above the longest run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle; request held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 50) check("ack", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // Status flags only: complete, errors, verify bits
  task automatic st(input logic [31:0] e);
    xfer(1'b0, OFF_STATUS, 32'h0);
    check("status", q & 32'hB3, e);
  endtask

  // Clear both error flags before the next command
  task automatic clr();
    wr(OFF_STATUS, 32'h30);
  endtask

  // Loads all six slots, sets the launch index, launches, waits
  task automatic run_cmd(input logic [15:0] s0, input logic [15:0] s1,
                         input logic [2:0] idx, input logic [15:0] w);
    for (int k = 0; k < 6; k++) begin
      wr(OFF_INDEX, 32'(k));
      wr(OFF_PARAM, {16'h0, (k == 0) ? s0 : (k == 1) ? s1 : w});
    end
    wr(OFF_INDEX, {29'h0, idx});
    wr(OFF_STATUS, 32'h80);
    waited = 0;
    while (done !== 1'b1 && waited < 2000) begin
      @(posedge clk);
      waited++;
    end
    if (waited >= 2000) check("complete", 32'h0, 32'h1);
  endtask

  task automatic prog(input logic [17:0] a, input logic [2:0] idx,
                      input logic [15:0] w);
    run_cmd({CMD_PROGRAM_EEPROM, 6'h0, a[17:16]}, a[15:0], idx, w);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("idle", {31'h0, done}, 32'h1);
    // Margin outside special mode is refused
    run_cmd({CMD_SET_FIELD_MARGIN, 8'h01}, 16'h3, 3'h1, 16'h0);
    st(32'hA0);
    check("ee margin", {29'h0, ee_m}, 32'h0);
    clr();
    wr(OFF_CONFIG, 32'h3);
    // Every level on the EEPROM target, then one above the range
    for (lv = 0; lv < 6; lv++) begin
      run_cmd({CMD_SET_FIELD_MARGIN, 6'h0, BLK_EEPROM}, 16'(lv), 3'h1,
              16'h0);
      st((lv < 5) ? 32'h80 : 32'hA0);
      clr();
      check("ee margin", {29'h0, ee_m}, (lv < 5) ? lv : 4);
      check("pf margin", {29'h0, pf_m}, 32'h0);
      // Refused level 5 keeps level 4, which biases programmed
      check("ee bias", {30'h0, ee_b},
            (lv == 0) ? 0 : (lv % 2 == 1 && lv < 5) ? 1 : 2);
    end
    // Selection codes beyond the two blocks are refused
    run_cmd({CMD_SET_FIELD_MARGIN, 6'h0, 2'h2}, 16'h1, 3'h1, 16'h0);
    st(32'hA0);
    check("ee margin", {29'h0, ee_m}, 32'h4);
    clr();
    // Flash target reaches both blocks
    run_cmd({CMD_SET_FIELD_MARGIN, 6'h0, BLK_PFLASH}, 16'h3, 3'h1, 16'h0);
    xfer(1'b0, OFF_MARGIN, 32'h0);
    check("margins", q, 32'h33);
    check("pf bias", {30'h0, pf_b}, 32'h1);
    // Unknown code
    run_cmd(16'h5500, 16'h0, 3'h1, 16'h0);
    st(32'hA0);
    clr();
    // Four words, then a reprogram without erase, on purpose, so that
    // the verify must miss
    prog(BASE, 3'h5, 16'h1234);
    st(32'h80);
    check("four word time", waited > 400, 32'h1);
    prog(BASE, 3'h5, 16'hFFFF);
    st(32'h83);
    prog(BASE + 18'h8, 3'h2, 16'h0);
    st(32'h80);
    check("one word time", waited < 120, 32'h1);
    // Refused launches: index, alignment, end, address, mode
    prog(BASE, 3'h1, 16'h0);
    st(32'hA0);
    clr();
    prog(BASE, 3'h6, 16'h0);
    st(32'hA0);
    clr();
    prog(BASE + 18'h11, 3'h2, 16'h0);
    st(32'hA0);
    clr();
    prog(BASE + 18'h7C, 3'h5, 16'h0);
    st(32'hA0);
    clr();
    prog(18'h30000, 3'h2, 16'h0);
    st(32'hA0);
    clr();
    wr(OFF_CONFIG, 32'h1);
    prog(BASE + 18'h20, 3'h2, 16'h0);
    st(32'hA0);
    clr();
    wr(OFF_CONFIG, 32'h3);
    // Protected top area refused, area below it still open
    wr(OFF_PROT, 32'h10040);
    prog(BASE + 18'h40, 3'h2, 16'h0);
    st(32'h90);
    clr();
    prog(BASE + 18'h10, 3'h2, 16'h0);
    st(32'h80);
    wr(OFF_PROT, 32'h0);
    // Unmapped place reads zero
    xfer(1'b0, 8'h3C, 32'h0);
    check("unmapped", q, 32'h0);
    // Sector erase makes the programmed word writable again
    run_cmd({CMD_ERASE_EE_SECTOR, 6'h0, BASE[17:16]}, BASE[15:0], 3'h1,
            16'h0);
    prog(BASE, 3'h2, 16'hFFFF);
    st(32'h80);
    wrap_up();
  end
endmodule
